// file: rtl/block_write_ram_loader.v
// Block write engine: copies host bytes into local RAM per channel.
// Assumes the host keeps its ordering and area restrictions.
// Operation
// RULE1: No processor or channel initialization performed
// RULE2: Any transmit channel may carry transfer
// RULE3: Start anywhere in table or program area
// RULE4: Host avoids carrying channel's own table bytes
// RULE5: Host stops, loads, formats, then starts
// RULE6: One control block per transfer
// RULE7: Channel program and line data held
// RULE8: Completion returns channel to stopped state
// RULE9: Interrupt at assigned level, none otherwise
// RULE10: Host writes zeros to reserved bytes
// RULE11: Twelve-bit start address in bytes 5-6
// RULE12: RAM address steps by one per byte
// RULE13: Bytes 0-4 hold host address, range
// RULE14: Completion writes status into bytes 6-7
// RULE15: Status returned by status input commands
// RULE16: Other channels keep running undisturbed
// RULE17: Mirror block read on receive channel
// RULE18: Loadable area totals 3584 bytes
// RULE19: Switch address in command bits 0-5
// RULE20: Table occupies first 512 bytes
// RULE21: Ends after range bytes moved
`include "block_write_map.vh"
module block_write_ram_loader #(
    parameter CHW = 3,
    parameter AW  = 12
) (
    input  wire           clk,
    input  wire           rst_n,
    input  wire [5:0]     switch_addr,
    input  wire           cmd_valid,
    input  wire [15:0]    cmd_word,
    input  wire [2:0]     cmd_op,
    input  wire [7:0]     cmd_data,
    input  wire           line_adapter_present,
    input  wire           mem_rvalid,
    input  wire [7:0]     mem_rdata,
    output reg            mem_req_ff,
    output reg  [23:0]    mem_addr_ff,
    output reg            mem_wvalid_ff,
    output reg  [7:0]     mem_wdata_ff,
    output reg  [7:0]     cmd_rdata_ff,
    output reg            cmd_ack_ff,
    output reg  [7:0]     chan_busy_ff,
    output reg  [7:0]     chan_stopped_ff,
    output reg            irq_ff,
    output reg  [3:0]     irq_level_ff,
    output reg  [CHW-1:0] irq_chan_ff
);
    // Command ops
    localparam OP_WR_CB    = 3'h0;
    localparam OP_RD_CB    = 3'h1;
    localparam OP_STOP     = 3'h2;
    localparam OP_START_WR = 3'h3;
    localparam OP_START_RD = 3'h4;
    localparam OP_SET_LVL  = 3'h5;
    localparam OP_STAT     = 3'h6;
    localparam OP_NXT_STAT = 3'h7;
    // States
    localparam S_IDLE  = 2'h0;
    localparam S_FETCH = 2'h1;
    localparam S_RAM   = 2'h2;
    localparam S_DONE  = 2'h3;

    reg [7:0]     cb_ff [0:(1<<CHW)-1][0:7];
    reg [3:0]     lvl_ff [0:(1<<CHW)-1];
    reg [1:0]     state_ff;
    reg [CHW-1:0] act_ch_ff;
    reg           act_read_ff;
    reg [15:0]    left_ff;
    reg [23:0]    haddr_ff;
    reg [AW-1:0]  raddr_ff;
    reg           ram_we;
    reg [7:0]     ram_wd;
    reg           adapt_s1_ff;
    reg           adapt_s2_ff;
    reg           adapt_s3_ff;
    reg           adapt_ok_ff;
    wire [7:0]    ram_q;
    integer       i;
    integer       j;

    // Decode channel field from low bits of the selection part
    function [CHW-1:0] chan_of;
        input [15:0] w;
        begin
            chan_of = w[CHW+3:4];
        end
    endfunction

    // Table sits at the bottom, program area directly above it
    function in_area;
        input [AW-1:0] a;
        begin
            in_area = (a < `LCT_BYTES + `CCP_BYTES); // RULE20
        end
    endfunction

    // Address and count steps shared by both transfer directions
    function [23:0] next_host;
        input [23:0] a;
        begin
            next_host = a + 24'h000001;
        end
    endfunction

    function [AW-1:0] next_ram;
        input [AW-1:0] a;
        begin
            next_ram = a + {{(AW-1){1'b0}}, 1'b1};
        end
    endfunction

    function [15:0] one_less;
        input [15:0] n;
        begin
            one_less = n - 16'h0001;
        end
    endfunction

    // Switch is a static strap, so commands decode from the first edge; starts are dropped unless adapt_ok_ff is set
    wire          hit = cmd_valid &&
        (cmd_word[`SW_ADDR_MSB:`SW_ADDR_LSB] == switch_addr); // RULE19
    wire [CHW-1:0] ch = chan_of(cmd_word);
    wire [2:0]     bi = cmd_word[2:0];
    wire           ch_tx = cmd_word[3];
    wire [AW-1:0]  start_a = {cb_ff[ch][`CB_RAM_ADDR_HI][3:0],
                              cb_ff[ch][`CB_RAM_ADDR_LO]}; // RULE11

    ram_byte_port #(.AW(AW)) u_ram (
        .clk   (clk),
        .we    (ram_we),
        .addr  (raddr_ff),
        .wdata (ram_wd),
        .rdata (ram_q)
    );

    // Adapter sense is a pin; a change counts once two stages agree
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adapt_s1_ff <= 1'b0;
            adapt_s2_ff <= 1'b0;
            adapt_s3_ff <= 1'b0;
            adapt_ok_ff <= 1'b0;
        end
        else
        begin
            adapt_s1_ff <= line_adapter_present;
            adapt_s2_ff <= adapt_s1_ff;
            adapt_s3_ff <= adapt_s2_ff;
            if (adapt_s2_ff == adapt_s3_ff)
            begin
                adapt_ok_ff <= adapt_s3_ff;
            end
        end
    end

    always @*
    begin
        ram_we = (state_ff == S_FETCH) && mem_rvalid && !act_read_ff;
        ram_wd = mem_rdata;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff        <= S_IDLE;
            act_ch_ff       <= {CHW{1'b0}};
            act_read_ff     <= 1'b0;
            left_ff         <= 16'h0000;
            haddr_ff        <= 24'h000000;
            raddr_ff        <= {AW{1'b0}};
            mem_req_ff      <= 1'b0;
            mem_addr_ff     <= 24'h000000;
            mem_wvalid_ff   <= 1'b0;
            mem_wdata_ff    <= 8'h00;
            cmd_rdata_ff    <= 8'h00;
            cmd_ack_ff      <= 1'b0;
            chan_busy_ff    <= 8'h00;
            chan_stopped_ff <= 8'hff;
            irq_ff          <= 1'b0;
            irq_level_ff    <= 4'h0;
            irq_chan_ff     <= {CHW{1'b0}};
            for (i = 0; i < (1<<CHW); i = i + 1)
            begin
                lvl_ff[i] <= 4'h0;
                for (j = 0; j < 8; j = j + 1)
                begin
                    cb_ff[i][j] <= 8'h00;
                end
            end
        end
        else
        begin
            cmd_ack_ff    <= 1'b0;
            irq_ff        <= 1'b0;
            mem_wvalid_ff <= 1'b0;
            // Decode touches only the selected channel's state
            if (hit) // RULE16
            begin
                cmd_ack_ff <= 1'b1;
                case (cmd_op)
                OP_WR_CB:
                    if (!chan_busy_ff[ch])
                    begin
                        cb_ff[ch][bi] <= cmd_data; // RULE13
                    end
                OP_RD_CB:
                    cmd_rdata_ff <= cb_ff[ch][bi];
                OP_STOP:
                    if (!chan_busy_ff[ch])
                    begin
                        chan_stopped_ff[ch] <= 1'b1;
                    end
                OP_SET_LVL:
                    lvl_ff[ch] <= cmd_data[3:0];
                OP_STAT, OP_NXT_STAT:
                    cmd_rdata_ff <= cb_ff[ch][`CB_STATUS]; // RULE15
                OP_START_WR, OP_START_RD:
                    // Only one transfer engine; a start while not idle is dropped
                    if (state_ff == S_IDLE && chan_stopped_ff[ch] &&
                        adapt_ok_ff &&
                        (ch_tx == (cmd_op == OP_START_WR))) // RULE2 RULE17
                    begin
                        act_ch_ff   <= ch; // RULE6
                        act_read_ff <= (cmd_op == OP_START_RD);
                        haddr_ff    <= {cb_ff[ch][`CB_HOST_ADDR_HI],
                                        cb_ff[ch][`CB_HOST_ADDR_MID],
                                        cb_ff[ch][`CB_HOST_ADDR_LO]};
                        left_ff     <= {cb_ff[ch][`CB_RANGE_HI],
                                        cb_ff[ch][`CB_RANGE_LO]}; // RULE13
                        raddr_ff    <= start_a; // RULE3
                        chan_busy_ff[ch]    <= 1'b1; // RULE7
                        chan_stopped_ff[ch] <= 1'b0; // RULE1
                        state_ff    <= S_FETCH;
                    end
                default:
                    cmd_ack_ff <= 1'b1;
                endcase
            end
            case (state_ff)
            S_IDLE:
                mem_req_ff <= 1'b0;
            S_FETCH:
                if (left_ff == 16'h0000)
                begin
                    mem_req_ff <= 1'b0;
                    state_ff   <= S_DONE; // RULE21
                end
                else if (!act_read_ff && !in_area(raddr_ff)) // RULE18
                begin
                    mem_req_ff <= 1'b0;
                    state_ff   <= S_DONE;
                end
                else if (act_read_ff)
                begin
                    mem_req_ff <= 1'b0;
                    state_ff   <= S_RAM;
                end
                else
                begin
                    mem_req_ff  <= 1'b1;
                    mem_addr_ff <= haddr_ff;
                    if (mem_rvalid)
                    begin
                        mem_req_ff <= 1'b0;
                        haddr_ff   <= next_host(haddr_ff);
                        left_ff    <= one_less(left_ff);
                        raddr_ff   <= next_ram(raddr_ff);
                        // RULE12
                    end
                end
            S_RAM:
                // RAM read has one cycle latency, ram_q valid now
                begin
                    mem_wvalid_ff <= 1'b1;
                    mem_addr_ff   <= haddr_ff;
                    mem_wdata_ff  <= ram_q;
                    haddr_ff      <= next_host(haddr_ff);
                    left_ff       <= one_less(left_ff);
                    raddr_ff      <= next_ram(raddr_ff); // RULE12
                    state_ff      <= S_FETCH;
                end
            S_DONE:
                begin
                    cb_ff[act_ch_ff][`CB_RAM_ADDR_HI] <= `STAT_TWO_DONE;
                    cb_ff[act_ch_ff][`CB_STATUS] <= (left_ff == 16'h0000) ?
                        `STAT_DONE : `STAT_RANGE_ERR; // RULE14
                    cb_ff[act_ch_ff][`CB_RAM_ADDR_LO] <= raddr_ff[7:0];
                    chan_busy_ff[act_ch_ff]    <= 1'b0;
                    chan_stopped_ff[act_ch_ff] <= 1'b1; // RULE8
                    if (lvl_ff[act_ch_ff] != 4'h0) // RULE9
                    begin
                        irq_ff       <= 1'b1;
                        irq_level_ff <= lvl_ff[act_ch_ff];
                        irq_chan_ff  <= act_ch_ff;
                    end
                    state_ff <= S_IDLE;
                end
            default:
                state_ff <= S_IDLE;
            endcase
        end
    end
endmodule

// file: rtl/block_write_map.vh
// Register offsets, field layouts and counts of the block write engine.
// Assumes inclusion by bare name from design files under rtl/.
`ifndef BLOCK_WRITE_MAP_VH
`define BLOCK_WRITE_MAP_VH
`define CB_HOST_ADDR_LO   3'h0
`define CB_HOST_ADDR_MID  3'h1
`define CB_HOST_ADDR_HI   3'h2
`define CB_RANGE_LO       3'h3
`define CB_RANGE_HI       3'h4
`define CB_RAM_ADDR_LO    3'h5
`define CB_RAM_ADDR_HI    3'h6
`define CB_STATUS         3'h7
`define LOADABLE_BYTES    12'he00
`define LCT_BYTES         12'h200
`define CCP_BYTES         12'hc00
`define FMT_BLOCK_WRITE   2'h2
`define STAT_DONE         8'h80
`define STAT_RANGE_ERR    8'h40
`define STAT_TWO_DONE     8'h80
`define SW_ADDR_MSB       15
`define SW_ADDR_LSB       10
`endif

// file: rtl/ram_byte_port.v
// Local RAM byte store used by the block write engine.
// Assumes single clock, one write or read per cycle.
module ram_byte_port #(
    parameter AW = 12
) (
    input  wire          clk,
    input  wire          we,
    input  wire [AW-1:0] addr,
    input  wire [7:0]    wdata,
    output reg  [7:0]    rdata
);
    reg [7:0] mem [0:(1<<AW)-1];

    always @(posedge clk)
    begin
        if (we)
        begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end
endmodule

// file: testbench/host_memory_model.sv
// Host memory model answering engine read requests.
// Assumes one clock; data is a fixed function of the address.
module host_memory_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        slow,
    input  wire logic        req,
    input  wire logic [23:0] addr,
    output logic             rvalid,
    output logic [7:0]       rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] wait_ff;
    // Idle data toggles so a stale byte is never mistaken for fresh
    always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
        rvalid <= 1'b0;
        rdata <= 8'h00;
        wait_ff <= 3'h0;
    end
    else if (req && !rvalid && wait_ff >= (slow ? 3'h3 : 3'h0))
    begin
        rvalid <= 1'b1;
        rdata <= addr[7:0] ^ 8'h3c;
        wait_ff <= 3'h0;
    end
    else
    begin
        rvalid <= 1'b0;
        rdata <= ~rdata;
        wait_ff <= (req && !rvalid) ? wait_ff + 3'h1 : 3'h0;
    end
endmodule

// file: testbench/block_write_ram_loader_sva.sv
// Port checker for the block write engine.
// Assumes binding to the engine top, one clock domain.
module block_write_ram_loader_sva (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [5:0]  switch_addr,
    input wire logic        cmd_valid,
    input wire logic [15:0] cmd_word,
    input wire logic        mem_rvalid,
    input wire logic        mem_req_ff,
    input wire logic [23:0] mem_addr_ff,
    input wire logic        cmd_ack_ff,
    input wire logic [7:0]  chan_busy_ff,
    input wire logic [7:0]  chan_stopped_ff,
    input wire logic        irq_ff,
    input wire logic [3:0]  irq_level_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire hit = cmd_valid && cmd_word[15:10] == switch_addr;
    a_ack_after_hit: assert property (hit |=> cmd_ack_ff)
        else $error("no ack after command");
    a_ack_has_cause: assert property (cmd_ack_ff |-> $past(hit))
        else $error("ack without command");
    a_irq_one_cycle: assert property (irq_ff |=> !irq_ff)
        else $error("irq longer than one cycle");
    a_irq_level_set: assert property (irq_ff |-> irq_level_ff != 4'h0)
        else $error("irq with no level");
    a_done_stops_chan: assert property
        (($past(chan_busy_ff) & ~chan_busy_ff & ~chan_stopped_ff) == 8'h00)
        else $error("finished channel not stopped");
    a_busy_held: assert property ((chan_busy_ff & chan_stopped_ff) == 8'h00)
        else $error("busy channel also stopped");
    a_req_held: assert property
        (mem_req_ff && !mem_rvalid |=> mem_req_ff && $stable(mem_addr_ff))
        else $error("read request dropped or moved");
    a_req_only_busy: assert property (mem_req_ff |-> chan_busy_ff != 8'h00)
        else $error("read request while idle");
    a_one_transfer: assert property ($onehot0(chan_busy_ff))
        else $error("more than one transfer");
    cover property (irq_ff);
    cover property (mem_req_ff && mem_rvalid);
    cover property ($fell(|chan_busy_ff));
endmodule
bind block_write_ram_loader block_write_ram_loader_sva u_sva (.clk, .rst_n,
    .switch_addr, .cmd_valid, .cmd_word, .mem_rvalid, .mem_req_ff,
    .mem_addr_ff, .cmd_ack_ff, .chan_busy_ff, .chan_stopped_ff, .irq_ff,
    .irq_level_ff);

// file: testbench/block_write_ram_loader_bench.sv
// Bench driving the engine command port against a host memory model.
// Assumes 50 ns clock and the designer's op codes.
module block_write_ram_loader_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, cmd_valid = 0, adapter = 1, slow = 0, ack;
    logic [15:0] cmd_word = 0;
    logic [2:0]  cmd_op = 0;
    logic [7:0]  cmd_data = 0, rd, mem_rdata, wdata, crd, busy, stopped;
    logic [5:0]  cmd_addr = 6'h2a;
    logic [23:0] maddr;
    logic [3:0]  lvl_o;
    logic [2:0]  ichan;
    logic        rvalid, req, wvalid, cack, irq;
    logic [7:0]  rq[$], wq[$];
    int          irq_n = 0, failures = 0, checks_done = 0, cycles = 0;
    always #25 clk = ~clk;
    block_write_ram_loader u_block_write_ram_loader (.clk(clk), .rst_n(rst_n),
        .switch_addr(6'h2a), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
        .cmd_op(cmd_op), .cmd_data(cmd_data), .line_adapter_present(adapter),
        .mem_rvalid(rvalid), .mem_rdata(mem_rdata), .mem_req_ff(req),
        .mem_addr_ff(maddr), .mem_wvalid_ff(wvalid), .mem_wdata_ff(wdata),
        .cmd_rdata_ff(crd), .cmd_ack_ff(cack), .chan_busy_ff(busy),
        .chan_stopped_ff(stopped), .irq_ff(irq), .irq_level_ff(lvl_o),
        .irq_chan_ff(ichan));
    host_memory_model u_host_memory_model (.clk(clk), .rst_n(rst_n),
        .slow(slow), .req(req), .addr(maddr), .rvalid(rvalid),
        .rdata(mem_rdata));
    always @(posedge clk)
    begin
        if (req && rvalid) rq.push_back(maddr[7:0]);
        if (wvalid) wq.push_back(wdata);
        if (irq) irq_n++;
        cycles++;
        // Whole run needs under 1000 cycles
        if (cycles == 2000)
        begin
            failures++;
            test_done();
        end
    end
    task check(input string what, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task cmd(input [2:0] op, ch, input tx, input [2:0] idx, input [7:0] d);
        @(posedge clk);
        cmd_valid <= 1;
        cmd_op <= op;
        cmd_word <= {cmd_addr, 3'h0, ch, tx, idx};
        cmd_data <= d;
        @(posedge clk);
        cmd_valid <= 0;
        #1 ack = cack;
        rd = crd;
    endtask
    task xfer(input [2:0] op, ch, input tx, input [3:0] lvl,
              input [11:0] ram, input [7:0] rng);
        logic [7:0] b[7];
        int n;
        b = '{8'h40, 8'h00, 8'h00, rng, 8'h00, ram[7:0], {4'h0, ram[11:8]}};
        cmd(3'h5, ch, tx, 3'h0, {4'h0, lvl});
        cmd(3'h2, ch, tx, 3'h0, 8'h00);
        for (n = 0; n < 7; n++) cmd(3'h0, ch, tx, n[2:0], b[n]);
        cmd(op, ch, tx, 3'h0, 8'h00);
        n = 0;
        do begin @(posedge clk); #1 n++; end while (busy !== 0 && n < 300);
        check("busy ends", n < 300, 1);
        repeat (3) @(posedge clk);
    endtask
    task test_done();
        if (failures == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1;
        cmd_addr <= 6'h15;
        cmd(3'h1, 3'h0, 1, 3'h0, 8'h00);
        check("foreign ack", ack, 0);
        cmd_addr <= 6'h2a;
        slow <= 1;
        // Crosses the table and program area boundary
        xfer(3'h3, 3'h2, 1, 4'h5, 12'h1fe, 8'h04);
        check("irq count", 8'(irq_n), 1);
        check("irq level", lvl_o, 5);
        check("irq chan", ichan, 2);
        check("stopped", stopped[2], 1);
        check("reads", 8'(rq.size()), 4);
        for (int i = 0; i < 4; i++) check("host addr", rq[i], 8'h40 + i);
        cmd(3'h6, 3'h2, 1, 3'h0, 8'h00);
        check("status", rd, 8'h80);
        cmd(3'h7, 3'h2, 1, 3'h0, 8'h00);
        check("next status", rd, 8'h80);
        cmd(3'h1, 3'h2, 1, 3'h6, 8'h00);
        check("status two", rd, 8'h80);
        cmd(3'h1, 3'h2, 1, 3'h5, 8'h00);
        check("ram addr", rd, 8'h02);
        slow <= 0;
        xfer(3'h3, 3'h5, 1, 4'h0, 12'h200, 8'h02);
        check("no irq", 8'(irq_n), 1);
        adapter <= 0;
        xfer(3'h3, 3'h4, 1, 4'h3, 12'h000, 8'h03);
        check("no adapter", 8'(rq.size()), 6);
        adapter <= 1;
        xfer(3'h4, 3'h1, 0, 4'h0, 12'h1fe, 8'h04);
        check("mirror n", 8'(wq.size()), 4);
        foreach (wq[i]) check("ram", wq[i], 8'h7c + (i & 1));
        // Runs off the top of the loadable area after one byte
        xfer(3'h3, 3'h6, 1, 4'h0, 12'hdff, 8'h02);
        check("area end", 8'(rq.size()), 7);
        cmd(3'h6, 3'h6, 1, 3'h0, 8'h00);
        check("area status", rd, 8'h40);
        test_done();
    end
endmodule
